// >>> core/frcc_timer.sv
`default_nettype none
module frcc_timer
  import frcc_pkg::*;
(
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  // cpu byte access
  input  wire logic [15:0] ADDR,
  input  wire logic        WR_STB,
  input  wire logic        RD_STB,
  input  wire logic [7:0]  WDATA,
  output logic      [7:0]  RDATA,
  // count source and irq
  input  wire logic        OTHER_TIMER_IRQ,
  output logic             MATCH_IRQ,
  // shared pin
  input  wire logic        SHARED_PIN_LATCH,
  input  wire logic        PIN_IN,
  output logic             PIN_OUT,
  output logic             PIN_OE_N
);
  logic [15:0]    cnt_r;
  logic [15:0]    cmp_r;
  logic [15:0]    cap_r;
  logic [15:0]    buf_r;
  logic [7:0]     tmc_r;
  logic [TMC_CPH:TMC_TOE] cfg_r;
  logic           tof_r;
  logic           tod_r;
  logic [7:0]     pdir_r;
  logic [7:0]     rdata_r;
  logic [DIV_W-1:0] div_r;
  logic           oth_r;
  logic           eq_r;
  logic           match_irq_r;
  logic           tick;
  logic           div4_tick;
  logic           eq;
  logic           match_now;
  logic           wr_tmc;
  logic           rd_lo;
  logic           rd_hi;
  frcc_rb_e       rb_r;
  frcc_rb_e       rb_nxt;
  frcc_cap_if     cap ();

  ////////////////////////////////////////////////////////////////
  // access decode
  assign wr_tmc = WR_STB && ADDR == ADR_TMC;
  assign rd_lo  = RD_STB && ADDR == ADR_TM_LO;
  assign rd_hi  = RD_STB && ADDR == ADR_TM_HI;

  ////////////////////////////////////////////////////////////////
  // count clock prescaler
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      div_r <= '0;
      oth_r <= 1'b0;
    end else begin
      div_r <= div_r + 1'b1;
      oth_r <= OTHER_TIMER_IRQ;
    end
  end

  // count enable by clock select
  assign div4_tick = div_r[1:0] == DIV4_END[1:0];
  always_comb begin
    case (tmc_r[TMC_CKH:TMC_CKL])
      CK_OTHER: tick = OTHER_TIMER_IRQ & ~oth_r;
      CK_DIV1:  tick = 1'b1;
      CK_DIV4:  tick = div4_tick;
      default:  tick = div_r == DIV32_END;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // free running counter, never cleared by a match
  // counts on after stop release too, so the value is then undefined
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) cnt_r <= CNT_RST;
    else if (tick) cnt_r <= cnt_r + 1'b1;
  end

  // compare register, byte writable
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      cmp_r <= CMP_RST;
    end else if (WR_STB) begin
      if (ADDR == ADR_CMP_LO) cmp_r[7:0] <= WDATA;
      if (ADDR == ADR_CMP_HI) cmp_r[15:8] <= WDATA;
    end
  end

  // match is the onset of equality; a rewrite onto the count also fires
  assign eq        = cnt_r == cmp_r;
  assign match_now = eq & ~eq_r;
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      eq_r        <= 1'b0;
      match_irq_r <= 1'b0;
    end else begin
      eq_r        <= eq;
      match_irq_r <= match_now;
    end
  end
  assign MATCH_IRQ = match_irq_r;

  ////////////////////////////////////////////////////////////////
  // mode control: configuration bits
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) cfg_r <= TMC_RST[TMC_CPH:TMC_TOE];
    else if (wr_tmc) cfg_r <= WDATA[TMC_CPH:TMC_TOE];
  end

  // overflow flag, hardware set beats software clear
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) tof_r <= TMC_RST[TMC_TOF];
    else if (tick && cnt_r == CNT_MAX) tof_r <= 1'b1;
    else if (wr_tmc && !WDATA[TMC_TOF]) tof_r <= 1'b0;
  end

  // output data: starts low on enable, toggles on match when inversion (TOC) is set
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) tod_r <= TMC_RST[TMC_TOD];
    else if (wr_tmc && WDATA[TMC_TOE] && !tmc_r[TMC_TOE]) tod_r <= 1'b0;
    else if (match_now && tmc_r[TMC_TOC]) tod_r <= ~tod_r;
  end

  // register image as read back, bit 7 read only
  assign tmc_r = {tod_r, tof_r, cfg_r};

  ////////////////////////////////////////////////////////////////
  // port direction register, upper bits stuck at one
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) pdir_r <= PDIR_RST;
    else if (WR_STB && ADDR == ADR_PDIR) pdir_r <= WDATA | PDIR_ONE;
  end

  // pin drive: buffer on when direction bit is zero (software sets latch)
  assign PIN_OE_N = pdir_r[PDIR_PIN];
  assign PIN_OUT  = SHARED_PIN_LATCH | (tmc_r[TMC_TOE] & tmc_r[TMC_TOD]);

  ////////////////////////////////////////////////////////////////
  // capture path
  assign cap.pin      = PIN_IN;
  assign cap.edge_sel = tmc_r[TMC_CPH:TMC_CPL];
  frcc_edge_det u_edge (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .cap   (cap)
  );
  // overwritten on each event, even mid read
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) cap_r <= CNT_RST;
    else if (cap.evt) cap_r <= cnt_r;
  end

  ////////////////////////////////////////////////////////////////
  // read buffer state: low read holds, high read releases
  always_comb begin
    case (rb_r)
      RB_LIVE:  rb_nxt = rd_lo ? RB_HELD : RB_LIVE;
      RB_HELD:  rb_nxt = rd_hi ? RB_DRAIN : RB_HELD;
      RB_DRAIN: rb_nxt = rd_hi ? RB_DRAIN : RB_LIVE;
      default:  rb_nxt = RB_LIVE;
    endcase
  end
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) rb_r <= RB_LIVE;
    else rb_r <= rb_nxt;
  end

  // buffer follows the count while live
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) buf_r <= CNT_RST;
    else if (rb_r == RB_LIVE) buf_r <= cnt_r;
  end

  ////////////////////////////////////////////////////////////////
  // registered read data, unmapped reads zero
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      rdata_r <= 8'h00;
    end else if (RD_STB) begin
      case (ADDR)
        // a live low byte read returns the count that the buffer freezes at this edge
        ADR_TM_LO:  rdata_r <= (rb_r == RB_LIVE) ? cnt_r[7:0] : buf_r[7:0];
        ADR_TM_HI:  rdata_r <= (rb_r == RB_LIVE) ? cnt_r[15:8] : buf_r[15:8];
        ADR_CAP_LO: rdata_r <= cap_r[7:0];
        ADR_CAP_HI: rdata_r <= cap_r[15:8];
        ADR_CMP_LO: rdata_r <= cmp_r[7:0];
        ADR_CMP_HI: rdata_r <= cmp_r[15:8];
        ADR_PDIR:   rdata_r <= pdir_r;
        ADR_TMC:    rdata_r <= tmc_r;
        default:    rdata_r <= 8'h00;
      endcase
    end
  end
  assign RDATA = rdata_r;

  ////////////////////////////////////////////////////////////////
  // checks
  property p_match_irq;
    @(posedge SYS_CLK) disable iff (!RST_N) (eq && !eq_r) |=> MATCH_IRQ ##1 !MATCH_IRQ;
  endproperty
  a_match_irq: assert property (p_match_irq) else $error("match irq missing");
  property p_count;
    @(posedge SYS_CLK) disable iff (!RST_N) tick |=> cnt_r == $past(cnt_r) + 16'h0001;
  endproperty
  a_count: assert property (p_count) else $error("counter did not advance");
  property p_div4;
    @(posedge SYS_CLK) disable iff (!RST_N) div4_tick |=> !div4_tick [*3] ##1 div4_tick;
  endproperty
  a_div4: assert property (p_div4) else $error("divide by four wrong");
  property p_toggle;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (match_now && tmc_r[TMC_TOC] && !wr_tmc) |=> tmc_r[TMC_TOD] != $past(tmc_r[TMC_TOD]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("output did not toggle");
  property p_hold;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (match_now && !tmc_r[TMC_TOC] && !wr_tmc) |=> $stable(tmc_r[TMC_TOD]);
  endproperty
  a_hold: assert property (p_hold) else $error("output changed without inversion");
  property p_start_low;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (wr_tmc && WDATA[TMC_TOE] && !tmc_r[TMC_TOE]) |=> !tmc_r[TMC_TOD];
  endproperty
  a_start_low: assert property (p_start_low) else $error("output not low on enable");
  property p_pdir;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (pdir_r & PDIR_ONE) == PDIR_ONE && PIN_OE_N == pdir_r[PDIR_PIN];
  endproperty
  a_pdir: assert property (p_pdir) else $error("direction register wrong");
  property p_capture;
    @(posedge SYS_CLK) disable iff (!RST_N) cap.evt |=> cap_r == $past(cnt_r);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");
  property p_ovf;
    @(posedge SYS_CLK) disable iff (!RST_N) (tick && cnt_r == CNT_MAX) |=> tmc_r[TMC_TOF];
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag not set");
  property p_frozen;
    @(posedge SYS_CLK) disable iff (!RST_N) (rb_r == RB_HELD) |=> $stable(buf_r);
  endproperty
  a_frozen: assert property (p_frozen) else $error("read buffer moved while held");
  property p_release;
    @(posedge SYS_CLK) disable iff (!RST_N) (rb_r == RB_DRAIN && !rd_hi) |=> rb_r == RB_LIVE;
  endproperty
  a_release: assert property (p_release) else $error("read buffer not released");
  c_match:   cover property (@(posedge SYS_CLK) disable iff (!RST_N) MATCH_IRQ);
  c_capture: cover property (@(posedge SYS_CLK) disable iff (!RST_N) cap.evt);
  c_pair:    cover property (@(posedge SYS_CLK) disable iff (!RST_N) rd_lo ##[1:8] rd_hi);
  c_ovf:     cover property (@(posedge SYS_CLK) disable iff (!RST_N) $rose(tmc_r[TMC_TOF]));
endmodule
`default_nettype wire

// >>> shared/frcc_pkg.sv
// Notes on behaviour
// - compare match raises irq, counter keeps running
// - clock select: other irq, clk, /4, /32
// - match with inversion enabled toggles output
// - output starts low when enabled
// - direction bit 0 drives pin; upper bits one
// - edge select: off, rise, fall, both
// - capture count within two clocks, hold
// - low byte read freezes read buffer
// - buffer unfreezes after high byte read ends
// - counter bytes read low then high
// - reset clears counter, then free running
// - count undefined after stop mode release
// - rewrite may shorten or double interval
// - mode control bit layout, reset zero
// - overflow flag set by hardware, software clears
// - reset loads compare with all ones
`default_nettype none
package frcc_pkg;
  // byte addresses
  localparam logic [15:0] ADR_TM_LO  = 16'hFF12;
  localparam logic [15:0] ADR_TM_HI  = 16'hFF13;
  localparam logic [15:0] ADR_CAP_LO = 16'hFF14;
  localparam logic [15:0] ADR_CAP_HI = 16'hFF15;
  localparam logic [15:0] ADR_CMP_LO = 16'hFF16;
  localparam logic [15:0] ADR_CMP_HI = 16'hFF17;
  localparam logic [15:0] ADR_PDIR   = 16'hFF23;
  localparam logic [15:0] ADR_TMC    = 16'hFF48;
  // mode control fields
  localparam int TMC_TOD = 7;
  localparam int TMC_TOF = 6;
  localparam int TMC_CPH = 5;
  localparam int TMC_CPL = 4;
  localparam int TMC_TOC = 3;
  localparam int TMC_CKH = 2;
  localparam int TMC_CKL = 1;
  localparam int TMC_TOE = 0;
  localparam int PDIR_PIN = 3;
  // reset values
  localparam logic [7:0]  TMC_RST  = 8'h00;
  localparam logic [7:0]  PDIR_RST = 8'hFF;
  localparam logic [7:0]  PDIR_ONE = 8'hE0;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [15:0] CMP_RST  = 16'hFFFF;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  // count clock select and divider
  localparam logic [1:0] CK_OTHER = 2'h0;
  localparam logic [1:0] CK_DIV1  = 2'h1;
  localparam logic [1:0] CK_DIV4  = 2'h2;
  localparam logic [1:0] CK_DIV32 = 2'h3;
  localparam int         DIV_W    = 5;
  localparam logic [4:0] DIV4_END  = 5'h03;
  localparam logic [4:0] DIV32_END = 5'h1F;
  // capture edge select
  localparam logic [1:0] EDG_OFF  = 2'h0;
  localparam logic [1:0] EDG_RISE = 2'h1;
  localparam logic [1:0] EDG_FALL = 2'h2;
  localparam logic [1:0] EDG_BOTH = 2'h3;
  // read buffer states
  typedef enum logic [1:0] {RB_LIVE = 2'h0, RB_HELD = 2'h1, RB_DRAIN = 2'h3} frcc_rb_e;
endpackage
`default_nettype wire

// >>> shared/frcc_cap_if.sv
`default_nettype none
interface frcc_cap_if;
  logic       pin;
  logic [1:0] edge_sel;
  logic       evt;
  modport det  (input pin, input edge_sel, output evt);
  modport user (output pin, output edge_sel, input evt);
endinterface
`default_nettype wire

// >>> core/frcc_edge_det.sv
`default_nettype none
module frcc_edge_det
  import frcc_pkg::*;
(
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rst_n,
  // capture signals
  frcc_cap_if.det    cap
);
  logic sync1_r;
  logic sync2_r;
  logic last_r;
  logic rise;
  logic fall;

  ////////////////////////////////////////////////////////////////
  // two-stage synchroniser, then a history stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      last_r  <= 1'b0;
    end else begin
      sync1_r <= cap.pin;
      sync2_r <= sync1_r;
      last_r  <= sync2_r;
    end
  end

  // edge qualify by select
  assign rise = sync2_r & ~last_r;
  assign fall = ~sync2_r & last_r;
  always_comb begin
    case (cap.edge_sel)
      EDG_RISE: cap.evt = rise;
      EDG_FALL: cap.evt = fall;
      EDG_BOTH: cap.evt = rise | fall;
      default:  cap.evt = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // checks
  property p_evt_sel;
    @(posedge clk) disable iff (!rst_n) cap.evt |-> cap.edge_sel != EDG_OFF;
  endproperty
  a_evt_sel: assert property (p_evt_sel) else $error("capture event while disabled");
  property p_evt_once;
    // a one-cycle pin pulse on both edges gives two events, one per transition
    @(posedge clk) disable iff (!rst_n)
      (cap.evt && $stable(cap.edge_sel)) |=> !cap.evt || $changed(sync2_r);
  endproperty
  a_evt_once: assert property (p_evt_once) else $error("double capture event");
endmodule
`default_nettype wire

// >>> tb/frcc_pin_model.sv
`default_nettype none
module frcc_pin_model (
  // timer side of the shared pin
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  // level applied by the outside source, and the resolved wire level
  input  wire logic ext_lvl,
  output logic      pin_lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////////////////////
  // wire level: timer drives while its buffer is on, else the outside source
  assign pin_lvl = pin_oe_n ? ext_lvl : pin_out;
endmodule
`default_nettype wire

// >>> tb/tb_frcc_timer.sv
`default_nettype none
module tb_frcc_timer;
  import frcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %s exp=%h got=%h", nm, e, g); end end
  ////////////////////////////////////////////////////////////////////////////////
  logic        sys_clk, rst_n, wr_stb, rd_stb, oti, match_irq, latch, pin_lvl;
  logic        pin_out, pin_oe_n, ext_lvl;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, lo, hi;
  int          err_total, checks_done, irq_seen, irq0;
  frcc_timer u_frcc_timer (.SYS_CLK(sys_clk), .RST_N(rst_n), .ADDR(addr), .WR_STB(wr_stb),
    .RD_STB(rd_stb), .WDATA(wdata), .RDATA(rdata), .OTHER_TIMER_IRQ(oti),
    .MATCH_IRQ(match_irq), .SHARED_PIN_LATCH(latch), .PIN_IN(pin_lvl),
    .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n));
  frcc_pin_model u_frcc_pin_model (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_lvl(ext_lvl), .pin_lvl(pin_lvl));
  ////////////////////////////////////////////////////////////////////////////////
  // clock and irq pulse counter
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (match_irq === 1'b1) irq_seen++;
  ////////////////////////////////////////////////////////////////////////////////
  // bus cycles and stimulus helpers
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk); addr <= a; wdata <= d; wr_stb <= 1'b1;
    @(posedge sys_clk); wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk); addr <= a; rd_stb <= 1'b1;
    @(posedge sys_clk); rd_stb <= 1'b0;
    @(negedge sys_clk); d = rdata;
  endtask
  task automatic pulse_other(input int n);
    repeat (n) begin
      @(posedge sys_clk); oti <= 1'b1;
      @(posedge sys_clk); oti <= 1'b0;
    end
    tick(4);
  endtask
  task automatic set_ext(input logic v);
    @(posedge sys_clk); ext_lvl <= v;
    tick(6);
  endtask
  task automatic rd_cnt(output logic [15:0] v);
    rd(ADR_TM_LO, lo); rd(ADR_TM_HI, hi);
    v = {hi, lo};
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    rd(ADR_TMC, lo);  `CHK("tmc_rst", 8'h00, lo)
    rd(ADR_PDIR, lo); `CHK("pdir_rst", 8'hFF, lo)
    rd(ADR_TM_LO, lo); rd(ADR_TM_HI, hi);
    `CHK("cnt_rst", 16'h0000, {hi, lo})
    `CHK("oe_rst", 1'b1, pin_oe_n)
    $display("test reset done");
  endtask
  task automatic t_count;
    pulse_other(5); rd(ADR_TM_LO, lo);
    `CHK("cnt_lo", 8'h05, lo)
    pulse_other(256); rd(ADR_TM_HI, hi);
    `CHK("cnt_hi_frozen", 8'h00, hi)
    tick(3); rd(ADR_TM_LO, lo); rd(ADR_TM_HI, hi);
    `CHK("cnt_live", 16'h0105, {hi, lo})
    $display("test count done");
  endtask
  task automatic t_dir;
    wr(ADR_PDIR, 8'h00); rd(ADR_PDIR, lo);
    `CHK("pdir_ones", 8'hE0, lo)
    `CHK("oe_on", 1'b0, pin_oe_n)
    tick(1); latch <= 1'b1; tick(1);
    `CHK("latch_drives", 1'b1, pin_lvl)
    latch <= 1'b0;
    $display("test direction done");
  endtask
  task automatic t_match;
    irq0 = irq_seen;
    wr(ADR_TMC, 8'h01); tick(1);
    `CHK("out_start", 1'b0, pin_out)
    wr(ADR_CMP_HI, 8'h01); wr(ADR_CMP_LO, 8'h08);
    wr(ADR_TMC, 8'h09); pulse_other(2);
    `CHK("no_irq_early", irq0, irq_seen)
    pulse_other(1);
    `CHK("irq_once", irq0 + 1, irq_seen)
    `CHK("out_toggled", 1'b1, pin_lvl)
    rd(ADR_TMC, lo); `CHK("tmc_tod", 8'h89, lo)
    rd(ADR_TM_LO, lo); rd(ADR_TM_HI, hi);
    `CHK("cnt_runs_on", 16'h0108, {hi, lo})
    wr(ADR_TMC, 8'h08); wr(ADR_TMC, 8'h09); tick(1);
    `CHK("out_restart", 1'b0, pin_out)
    rd(ADR_TMC, lo); `CHK("tod_cleared", 8'h09, lo)
    wr(ADR_TMC, 8'h01); wr(ADR_CMP_LO, 8'h09); pulse_other(1);
    `CHK("irq_no_inv", irq0 + 2, irq_seen)
    `CHK("out_kept", 1'b0, pin_out)
    $display("test match done");
  endtask
  task automatic t_capture;
    rd(ADR_CAP_LO, lo); `CHK("cap_off", 8'h00, lo)
    wr(ADR_PDIR, 8'hFF); wr(ADR_TMC, 8'h10); set_ext(1'b0);
    set_ext(1'b1); wr(ADR_TMC, 8'h00); rd(ADR_CAP_LO, lo); rd(ADR_CAP_HI, hi);
    `CHK("cap_rise", 16'h0109, {hi, lo})
    wr(ADR_TMC, 8'h10); pulse_other(1); set_ext(1'b0);
    wr(ADR_TMC, 8'h00); rd(ADR_CAP_LO, lo);
    `CHK("cap_hold", 8'h09, lo)
    wr(ADR_TMC, 8'h30); set_ext(1'b1); wr(ADR_TMC, 8'h00); rd(ADR_CAP_LO, lo);
    `CHK("cap_both", 8'h0A, lo)
    pulse_other(1); wr(ADR_TMC, 8'h20); set_ext(1'b0); wr(ADR_TMC, 8'h00);
    rd(ADR_CAP_LO, lo);
    `CHK("cap_fall", 8'h0B, lo)
    $display("test capture done");
  endtask
  task automatic t_clock;
    logic [15:0] c0, c1;
    wr(ADR_TMC, 8'h02); rd_cnt(c0); tick(28); rd_cnt(c1);
    `CHK("div1_rate", 16'h0020, c1 - c0)
    wr(ADR_TMC, 8'h04); rd_cnt(c0); tick(28); rd_cnt(c1);
    `CHK("div4_rate", 16'h0008, c1 - c0)
    wr(ADR_TMC, 8'h06); rd_cnt(c0); tick(60); rd_cnt(c1);
    `CHK("div32_rate", 16'h0002, c1 - c0)
    $display("test clock select done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // closing report
  task automatic final_report;
    $display("checks=%0d errors=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    sys_clk = 1'b0; rst_n = 1'b0; wr_stb = 1'b0; rd_stb = 1'b0; oti = 1'b0;
    addr = 16'h0000; wdata = 8'h00; latch = 1'b0; ext_lvl = 1'b0;
    err_total = 0; checks_done = 0; irq_seen = 0;
    tick(4);
    rst_n <= 1'b1;
    t_reset();
    t_count();
    t_dir();
    t_match();
    t_capture();
    t_clock();
    final_report();
  end
  initial begin
    #6000000;
    err_total++;
    final_report();
  end
endmodule
`default_nettype wire
